//--- pcs_params.svh
// Purpose: constants for the program counter and return stack block
// Assumes: 13-bit program address, 8-level stack
// Notes:   included by every design file of the block
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_PC_W        13
`define PCS_STACK_DEPTH 8
`define PCS_SP_W        3
`define PCS_TGT_W       11
`define PCS_PAGE_BIT    3
`define PCS_HIGH_W      5
`define PCS_PC_RESET    13'h0000
`define PCS_LATCH_RESET 8'h00
`endif

//--- pcs_pkg.sv
// Purpose: types for the program counter and return stack block
// Assumes: pcs_params.svh constants
// Notes:   flow encodings shared by core model and program counter
`include "pcs_params.svh"
package pcs_pkg;
  typedef logic [`PCS_PC_W-1:0] pcs_addr_t;
  typedef enum logic [2:0]
  {
    PCS_OP_NEXT,
    PCS_OP_HOLD,
    PCS_OP_GOTO,
    PCS_OP_CALL,
    PCS_OP_RET,
    PCS_OP_IRQ
  } pcs_op_t;
endpackage : pcs_pkg

//--- pcs_stack.sv
// Purpose: circular return-address stack
// Assumes: push and pop never asserted together
// Notes:   no overflow or underflow detection, pointer simply wraps
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module pcs_stack
(
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 push,
  input  wire logic                 pop,
  input  wire pcs_pkg::pcs_addr_t   pushAddr,
  output      pcs_pkg::pcs_addr_t   topAddr
);
  import pcs_pkg::*;
  typedef struct packed
  {
    logic [`PCS_SP_W-1:0] sp;
  } pcs_stk_state_t;
  pcs_stk_state_t state_reg;
  pcs_stk_state_t state_next;
  pcs_addr_t      mem [`PCS_STACK_DEPTH];
  logic [`PCS_SP_W-1:0] popIdx;

  assign popIdx  = state_reg.sp - 3'h1;
  assign topAddr = mem[popIdx];

  always_comb
  begin
    state_next = state_reg;
    if (push)
      state_next.sp = state_reg.sp + 3'h1;
    else if (pop)
      state_next.sp = popIdx;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
    if (push)
      mem[state_reg.sp] <= pushAddr;
  end

  AST_WRAP: assert property (@(posedge ref_clk) disable iff (reset)
    push && !pop |=> state_reg.sp == $past(state_reg.sp) + 3'h1)
    else $error("stack pointer did not advance on push");

  AST_POP_BACK: assert property (@(posedge ref_clk) disable iff (reset)
    pop && !push |=> state_reg.sp == $past(state_reg.sp) - 3'h1)
    else $error("stack pointer did not step back on pop");

  AST_PUSH_MEM: assert property (@(posedge ref_clk) disable iff (reset)
    push |=> mem[$past(state_reg.sp)] == $past(pushAddr))
    else $error("pushed address not stored at pointer");
endmodule : pcs_stack
`default_nettype wire

//--- pcs_latch.sv
// Purpose: holds the high-byte latch written from the data space
// Assumes: write strobe comes from core logic on ref_clk
// Notes:   stack activity never touches this register
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module pcs_latch
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output      logic [7:0] value
);
  import pcs_pkg::*;
  typedef struct packed
  {
    logic [7:0] v;
  } pcs_lat_state_t;
  pcs_lat_state_t state_reg;
  pcs_lat_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (wrEn)
      state_next.v = wrData;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_reg.v <= `PCS_LATCH_RESET;
    else
      state_reg <= state_next;
  end

  assign value = state_reg.v;

  AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    !wrEn |=> value == $past(value))
    else $error("latch changed without a write");
endmodule : pcs_latch
`default_nettype wire

//--- pcs_program_counter.sv
// Purpose: program counter with paging and hardware return stack
// Assumes: core issues one flow op per cycle; low-byte write is exclusive
// Notes:   outputs are registered; stack is invisible to software
// Behaviour
// - keep a 13-bit counter addressing the next instruction fetch.
// - low byte readable and writable by software via data space.
// - upper bits never directly accessed; software loads them only through the latch.
// - eight 13-bit stack entries, pointer hidden from software.
// - push counter on CALL or interrupt branch.
// - pop stack into counter on the single RET op.
// - push and pop leave the high latch untouched.
// - stack wraps circularly; ninth push overwrites the first.
// - CALL and GOTO take an 11-bit target from the instruction.
// - top address bit comes from latch bit 3 on CALL/GOTO.
// - full 13-bit return address saved, no page setup for returns.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module pcs_program_counter
(
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire pcs_pkg::pcs_op_t        flowOp,
  input  wire logic [`PCS_TGT_W-1:0]   target,
  input  wire pcs_pkg::pcs_addr_t      irqVector,
  input  wire logic                    lowWrEn,
  input  wire logic [7:0]              lowWrData,
  input  wire logic                    latchWrEn,
  input  wire logic [7:0]              latchWrData,
  output      pcs_pkg::pcs_addr_t      fetchAddr,
  output      logic [7:0]              lowRdData,
  output      logic [7:0]              latchRdData
);
  import pcs_pkg::*;

  typedef struct packed
  {
    pcs_addr_t  pc;
    logic [7:0] latch;
  } pcs_pc_state_t;

  pcs_pc_state_t state_reg;
  pcs_pc_state_t state_next;
  logic          doPush;
  logic          doPop;
  pcs_addr_t     retAddr;
  pcs_addr_t     pushAddr;
  logic [7:0]    latchVal;
  pcs_addr_t     pageTarget;

  // latch lives apart so stack logic has no path to it
  pcs_latch u_latch
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wrEn    (latchWrEn),
    .wrData  (latchWrData),
    .value   (latchVal)
  );

  // a low-byte write wins the cycle, so the stack sits it out as well
  assign doPush   = !lowWrEn &&
                    (flowOp == PCS_OP_CALL || flowOp == PCS_OP_IRQ);
  assign doPop    = !lowWrEn && (flowOp == PCS_OP_RET);
  // return address is the next sequential one, whole 13 bits
  assign pushAddr = state_reg.pc + 13'h0001;

  pcs_stack u_stack
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .push     (doPush),
    .pop      (doPop),
    .pushAddr (pushAddr),
    .topAddr  (retAddr)
  );

  // latch bits 2:0 are ignored here: only one page bit on this part
  assign pageTarget = {latchVal[`PCS_PAGE_BIT], 1'b0, target};

  always_comb
  begin
    state_next       = state_reg;
    state_next.latch = latchVal;
    if (lowWrEn)
      state_next.pc = {latchVal[`PCS_HIGH_W-1:0], lowWrData};
    else
      unique case (flowOp)
        PCS_OP_NEXT: state_next.pc = state_reg.pc + 13'h0001;
        PCS_OP_HOLD: state_next.pc = state_reg.pc;
        PCS_OP_GOTO: state_next.pc = pageTarget;
        PCS_OP_CALL: state_next.pc = pageTarget;
        PCS_OP_RET:  state_next.pc = retAddr;
        PCS_OP_IRQ:  state_next.pc = irqVector;
        default:     state_next.pc = state_reg.pc;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg.pc    <= `PCS_PC_RESET;
      state_reg.latch <= `PCS_LATCH_RESET;
    end
    else
      state_reg <= state_next;
  end

  assign fetchAddr   = state_reg.pc;
  assign lowRdData   = state_reg.pc[7:0];
  assign latchRdData = state_reg.latch;

  // stack has no software port: only push/pop reach it

  AST_RESET_ZERO: assert property (@(posedge ref_clk)
    reset |=> fetchAddr == 13'h0000)
    else $error("counter not zero after reset");

  AST_INCREMENT: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && flowOp == PCS_OP_NEXT |=>
      fetchAddr == $past(fetchAddr) + 13'h0001)
    else $error("sequential fetch did not increment");

  AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    lowWrEn |=> fetchAddr == {$past(latchVal[4:0]), $past(lowWrData)})
    else $error("low-byte write did not load full address");

  AST_PAGE: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && (flowOp == PCS_OP_GOTO || flowOp == PCS_OP_CALL) |=>
      fetchAddr[12] == $past(latchVal[3]) &&
      fetchAddr[10:0] == $past(target))
    else $error("branch target or page bit wrong");

  AST_CALL_RET: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && flowOp == PCS_OP_CALL ##1
      !lowWrEn && flowOp == PCS_OP_RET |=>
      fetchAddr == $past(fetchAddr, 2) + 13'h0001)
    else $error("return did not restore call address");

  AST_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && flowOp == PCS_OP_IRQ |=> fetchAddr == $past(irqVector))
    else $error("interrupt branch not taken");

  AST_LATCH_KEEP: assert property (@(posedge ref_clk) disable iff (reset)
    (doPush || doPop) && !latchWrEn |=> latchVal == $past(latchVal))
    else $error("stack activity changed latch");

  AST_LOW_READ: assert property (@(posedge ref_clk) disable iff (reset)
    lowRdData == fetchAddr[7:0])
    else $error("low-byte readback mismatch");

  AST_BIT11: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && (flowOp == PCS_OP_GOTO || flowOp == PCS_OP_CALL) |=>
      fetchAddr[11] == 1'b0)
    else $error("branch left address bit 11 set");

  AST_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && flowOp == PCS_OP_HOLD |=> $stable(fetchAddr))
    else $error("counter moved while holding");

  // top of stack right after a push must be the full return address
  AST_PUSH_TOP: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && (flowOp == PCS_OP_CALL || flowOp == PCS_OP_IRQ) |=>
      retAddr == $past(fetchAddr) + 13'h0001)
    else $error("pushed return address wrong");

  AST_POP_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
    !lowWrEn && flowOp == PCS_OP_RET |=> fetchAddr == $past(retAddr))
    else $error("return did not load top of stack");

  COV_CALL_RET: cover property (@(posedge ref_clk) disable iff (reset)
    flowOp == PCS_OP_CALL ##[1:4] flowOp == PCS_OP_RET);
  COV_IRQ: cover property (@(posedge ref_clk) disable iff (reset)
    flowOp == PCS_OP_IRQ);
  COV_LOW_WRITE: cover property (@(posedge ref_clk) disable iff (reset)
    lowWrEn);
  COV_PAGE_ONE: cover property (@(posedge ref_clk) disable iff (reset)
    flowOp == PCS_OP_GOTO && latchVal[`PCS_PAGE_BIT]);
  COV_BACK2BACK: cover property (@(posedge ref_clk) disable iff (reset)
    flowOp == PCS_OP_CALL ##1 flowOp == PCS_OP_RET);
endmodule : pcs_program_counter
`default_nettype wire

//--- pcs_core_model.sv
// Purpose: decode/execute model that issues flow ops and data writes
// Assumes: HOLD and no write strobes between calls
// Notes:   interrupt vector value is arbitrary
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module pcs_core_model
#(
  parameter pcs_pkg::pcs_addr_t IRQ_VEC = 13'h0004
)
(
  input  wire logic                  ref_clk,
  output var  pcs_pkg::pcs_op_t      flowOp,
  output var  logic [`PCS_TGT_W-1:0] target,
  output var  pcs_pkg::pcs_addr_t    irqVector,
  output var  logic                  lowWrEn,
  output var  logic [7:0]            lowWrData,
  output var  logic                  latchWrEn,
  output var  logic [7:0]            latchWrData
);
  import pcs_pkg::*;
  initial
  begin
    flowOp      = PCS_OP_HOLD;
    target      = 11'h000;
    irqVector   = IRQ_VEC;
    lowWrEn     = 1'b0;
    lowWrData   = 8'h00;
    latchWrEn   = 1'b0;
    latchWrData = 8'h00;
  end
  // one op per cycle; stale data inverted so nothing leans on it
  task automatic step(input pcs_op_t o, input logic [10:0] t,
                      input logic lw, input logic [7:0] ld,
                      input logic hw, input logic [7:0] hd);
    @(posedge ref_clk);
    flowOp      <= o;
    target      <= t;
    lowWrEn     <= lw;
    lowWrData   <= ld;
    latchWrEn   <= hw;
    latchWrData <= hd;
    @(posedge ref_clk);
    flowOp      <= PCS_OP_HOLD;
    target      <= ~t;
    lowWrEn     <= 1'b0;
    lowWrData   <= ~ld;
    latchWrEn   <= 1'b0;
    latchWrData <= ~hd;
  endtask : step
  // two ops on consecutive edges, no idle cycle between them
  task automatic pair(input pcs_op_t a, input logic [10:0] ta,
                      input pcs_op_t b);
    @(posedge ref_clk);
    flowOp <= a;
    target <= ta;
    @(posedge ref_clk);
    flowOp <= b;
    @(posedge ref_clk);
    flowOp <= PCS_OP_HOLD;
    target <= ~ta;
  endtask : pair
endmodule : pcs_core_model
`default_nettype wire

//--- test_program_counter_and_call_stack.sv
// Purpose: self-checking bench for counter, paging and return stack
// Assumes: result of an op is registered at the edge after it is issued
// Notes:   each scenario is its own task
`timescale 1ns/1ps
`default_nettype none
module test_program_counter_and_call_stack;
  import pcs_pkg::*;
  logic      ref_clk = 1'b0;
  logic      reset = 1'b1;
  int        errors = 0;
  int        checked = 0;
  pcs_op_t   flowOp;
  logic [10:0] target;
  pcs_addr_t irqVector, fetchAddr;
  logic      lowWrEn, latchWrEn;
  logic [7:0] lowWrData, latchWrData, lowRdData, latchRdData;
  always #10 ref_clk = ~ref_clk;
  pcs_core_model i_pcs_core_model (.ref_clk(ref_clk), .flowOp(flowOp),
    .target(target), .irqVector(irqVector), .lowWrEn(lowWrEn),
    .lowWrData(lowWrData), .latchWrEn(latchWrEn),
    .latchWrData(latchWrData));
  pcs_program_counter i_pcs_program_counter (.ref_clk(ref_clk),
    .reset(reset), .flowOp(flowOp), .target(target),
    .irqVector(irqVector), .lowWrEn(lowWrEn), .lowWrData(lowWrData),
    .latchWrEn(latchWrEn), .latchWrData(latchWrData),
    .fetchAddr(fetchAddr), .lowRdData(lowRdData),
    .latchRdData(latchRdData));
  task automatic check(input pcs_addr_t seen, input pcs_addr_t exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic op(input pcs_op_t o, input logic [10:0] t);
    i_pcs_core_model.step(o, t, 1'b0, 8'h00, 1'b0, 8'h00);
    #1;
  endtask : op
  task automatic latch(input logic [7:0] d);
    i_pcs_core_model.step(PCS_OP_HOLD, 11'h000, 1'b0, 8'h00, 1'b1, d);
    #1;
  endtask : latch
  task automatic t_reset();
    check(fetchAddr, 13'h0000);
    repeat (3) op(PCS_OP_NEXT, 11'h000);
    check(fetchAddr, 13'h0003);
  endtask : t_reset
  task automatic t_goto();
    latch(8'hF8);
    op(PCS_OP_GOTO, 11'h7FF);
    check(fetchAddr, 13'h17FF);
    check({5'h00, latchRdData}, 13'h00F8);
    latch(8'hF7);
    op(PCS_OP_GOTO, 11'h7FF);
    check(fetchAddr, 13'h07FF);
  endtask : t_goto
  task automatic t_low();
    latch(8'hF5);
    i_pcs_core_model.step(PCS_OP_NEXT, 11'h000, 1'b1, 8'hA5, 1'b0, 8'h00);
    #1;
    check(fetchAddr, 13'h15A5);
    check({5'h00, lowRdData}, 13'h00A5);
    // latch written in the same cycle must not be used yet
    i_pcs_core_model.step(PCS_OP_HOLD, 11'h000, 1'b1, 8'h3C, 1'b1, 8'hE0);
    #1;
    check(fetchAddr, 13'h153C);
    op(PCS_OP_NEXT, 11'h000);
    check(fetchAddr, 13'h153D);
  endtask : t_low
  task automatic t_callret();
    op(PCS_OP_CALL, 11'h100);
    check(fetchAddr, 13'h0100);
    op(PCS_OP_IRQ, 11'h000);
    check(fetchAddr, 13'h0004);
    op(PCS_OP_RET, 11'h000);
    check(fetchAddr, 13'h0101);
    op(PCS_OP_RET, 11'h000);
    check(fetchAddr, 13'h153E);
    check({5'h00, latchRdData}, 13'h00E0);
  endtask : t_callret
  task automatic t_wrap();
    pcs_addr_t exp;
    for (int k = 1; k <= 9; k++)
      op(PCS_OP_CALL, 11'(k * 8));
    // ninth push lands on the first, so pop nine sees push nine again
    for (int j = 1; j <= 9; j++)
    begin
      exp = (j == 9) ? 13'h0041 : 13'(8 * (9 - j) + 1);
      op(PCS_OP_RET, 11'h000);
      check(fetchAddr, exp);
    end
    check({5'h00, latchRdData}, 13'h00E0);
  endtask : t_wrap
  task automatic t_rerun();
    i_pcs_core_model.pair(PCS_OP_CALL, 11'h222, PCS_OP_RET);
    #1;
    check(fetchAddr, 13'h0042);
    op(PCS_OP_CALL, 11'h222);
    check(fetchAddr, 13'h0222);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    check(fetchAddr, 13'h0000);
    check({5'h00, latchRdData}, 13'h0000);
    op(PCS_OP_NEXT, 11'h000);
    check(fetchAddr, 13'h0001);
  endtask : t_rerun
  task automatic results();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // whole run is under a hundred cycles; this is far beyond it
  initial
  begin
    #100000;
    errors++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_goto();
    t_low();
    t_callret();
    t_wrap();
    t_rerun();
    results();
  end
endmodule : test_program_counter_and_call_stack
`default_nettype wire
